/* File: logic/dpef_pkg.sv */
/*
 * dpef_pkg: constants shared by the debug port error flag logic.
 * Assumes a single core clock domain; all users write dpef_pkg::name.
 */
package dpef_pkg;
    // bit positions in debug_status_low
    localparam int unsigned OVERRUN_BIT    = 4;
    localparam int unsigned NO_RESP_BIT    = 3;
    localparam int unsigned READ_INV_BIT   = 2;
    localparam int unsigned ILLEGAL_BIT    = 1;
    // value of the status byte after reset
    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    // value of the host data register after reset
    localparam logic [7:0]  HOST_DATA_RESET = 8'h00;
    // filler byte for failed or illegal accesses
    localparam logic [7:0]  FILLER_BYTE    = 8'hEE;
    // free cycle search limit in core clock cycles
    localparam int unsigned CYCLE_SELECT_A_LIMIT    = 512;
    localparam int unsigned CYCLE_SELECT_A_CNT_W    = 10;
    localparam logic [9:0]  CYCLE_SELECT_A_CNT_ZERO = 10'h000;
    localparam logic [9:0]  CYCLE_SELECT_A_CNT_LAST = 10'(CYCLE_SELECT_A_LIMIT - 1);

    // access tracker states
    typedef enum logic [1:0] {
        DPEF_IDLE,
        DPEF_BUSY,
        DPEF_HOLD
    } dpef_acc_state_t;
endpackage

/* File: logic/dpef_sync.sv */
/*
 * dpef_sync: two-stage synchroniser for a level from outside the clock domain.
 * Assumes clk_sys and asynchronous active-high rst.
 */
`timescale 1ns/1ps
module dpef_sync
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // level
    input  wire logic asyncIn,
    output logic      syncOut
);
    logic stage1_ff;

    // first stage read only by the second
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            stage1_ff <= 1'b0;
            syncOut   <= 1'b0;
        end
        else
        begin
            stage1_ff <= asyncIn;
            syncOut   <= stage1_ff;
        end
    end
endmodule

/* File: logic/dpef_flag.sv */
/*
 * dpef_flag: one sticky status flag, set by hardware, cleared by a clear pulse.
 * Assumes set and clear pulses are on clk_sys; set wins over clear.
 */
`timescale 1ns/1ps
module dpef_flag
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // control
    input  wire logic setPulse,
    input  wire logic clrPulse,
    output logic      flag_ff
);
    logic nxt_flag;

    // holds until cleared, set wins
    assign nxt_flag = setPulse | (flag_ff & ~clrPulse);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end
endmodule

/* File: logic/dpef_error_flags.sv */
/*
 * dpef_error_flags: error status of the single-wire debug controller.
 * Holds the overrun, no-response, read-invalid and illegal-access flags,
 * substitutes filler data and aborts failed internal accesses.
 * Assumes the wire decoder delivers one-cycle command events on clk_sys,
 * and the bus side reports access progress on clk_sys.  The wire pin and
 * the external wait input are asynchronous and synchronised here.
 */
`timescale 1ns/1ps
module dpef_error_flags
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // debug wire pin and external wait (asynchronous)
    input  wire logic       debugWirePin,
    input  wire logic       externalWaitInput,
    // configuration from the controller
    input  wire logic       ackEnable,
    input  wire logic       cycleSelectA,
    input  wire logic       clockInStopSelect,
    input  wire logic       debugModeActive,
    // core mode status
    input  wire logic       stopMode,
    input  wire logic       waitMode,
    input  wire logic       waitReturning,
    // command events from the wire decoder
    input  wire logic       cmdStart,
    input  wire logic       cmdIsMemAccess,
    input  wire logic       cmdIsWrite,
    input  wire logic       cmdIsSamplePc,
    input  wire logic       cmdIsEnterDebug,
    input  wire logic       cmdIsCoreReg,
    input  wire logic       cmdIllegal,
    input  wire logic       resyncDone,
    input  wire logic       ackPending,
    input  wire logic       retrieveStart,
    // internal bus side
    input  wire logic       busFreeCycle,
    input  wire logic       busDone,
    input  wire logic       busEccError,
    input  wire logic [7:0] busReadData,
    output logic            busRequest,
    output logic            busAbort,
    output logic            enterDebugReq,
    // status register access
    input  wire logic       statusWrite,
    input  wire logic [7:0] statusWrData,
    output logic [7:0]      debugStatusLow,
    // data returned to the host
    input  wire logic       dataByteTake,
    output logic [7:0]      hostReadData_ff
);
    logic                         wirePinSync;
    logic                         extWaitSync;
    logic                         overrunFlag;
    logic                         noResponseFlag;
    logic                         readInvalidFlag;
    logic                         illegalAccessFlag;
    dpef_pkg::dpef_acc_state_t    accState_ff;
    dpef_pkg::dpef_acc_state_t    nxt_accState;
    logic [dpef_pkg::CYCLE_SELECT_A_CNT_W-1:0] stealCnt_ff;
    logic [dpef_pkg::CYCLE_SELECT_A_CNT_W-1:0] nxt_stealCnt;
    logic                         accIsWrite_ff;
    logic                         failSticky_ff;
    logic                         nxt_failSticky;
    logic                         enterPending_ff;
    logic                         nxt_enterPending;
    logic                         wirePrev_ff;
    logic                         accActive;
    logic                         memCmd;
    logic                         startAccess;
    logic                         overrunSet;
    logic                         stealTimeout;
    logic                         lateRetrieve;
    logic                         lateWrite;
    logic                         stopNoClock;
    logic                         waitEnterDebug;
    logic                         waitCoreReg;
    logic                         waitReturnCmd;
    logic                         noRespSet;
    logic                         wireFall;
    logic                         noAckMode;
    logic                         accBusy;
    logic                         accHold;
    logic                         readInvSet;
    logic                         illegalSet;
    logic                         clrNoResp;
    logic                         clrReadInv;
    logic                         clrIllegal;
    logic                         fillerNoResp;
    logic                         fillerIllegal;

    // write-one-to-clear hit on one status bit
    function automatic logic w1cHit
    (
        input logic        wr,
        input logic [7:0]  data,
        input int unsigned pos
    );
        return wr & data[pos];
    endfunction

    // synchronise asynchronous pin levels
    dpef_sync u_syncPin
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (debugWirePin),
        .syncOut (wirePinSync)
    );

    dpef_sync u_syncWait
    (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (externalWaitInput),
        .syncOut (extWaitSync)
    );

    // classify command and progress events
    assign accActive   = (accState_ff != dpef_pkg::DPEF_IDLE);
    assign memCmd      = cmdIsMemAccess | cmdIsSamplePc;
    assign wireFall    = wirePrev_ff & ~wirePinSync;
    assign noAckMode   = ~ackEnable | cycleSelectA;
    assign overrunSet  = (cmdStart & accActive)
                       | (ackEnable & ackPending & wireFall);
    // accesses start only when clean, legal and core clock is available
    assign stopNoClock = cmdStart & stopMode & ~clockInStopSelect & memCmd;
    assign startAccess = cmdStart & memCmd & ~overrunFlag & ~accActive
                       & ~cmdIllegal & ~stopNoClock;
    assign stealTimeout = accBusy
                        & ~busFreeCycle
                        & (stealCnt_ff == dpef_pkg::CYCLE_SELECT_A_CNT_LAST);
    assign lateRetrieve = noAckMode & retrieveStart & accActive & ~busDone;
    assign lateWrite    = noAckMode & cmdStart & accActive & accIsWrite_ff
                        & ~busDone;
    assign waitEnterDebug = cmdStart & cmdIsEnterDebug & waitMode;
    assign waitCoreReg    = cmdStart & cmdIsCoreReg & waitMode;
    assign waitReturnCmd  = cmdStart & waitReturning;
    assign noRespSet = stealTimeout | lateRetrieve | lateWrite | stopNoClock
                     | waitEnterDebug | waitCoreReg | waitReturnCmd;

    // status side decode: hardware sets, host clears by writing one
    assign accBusy       = (accState_ff == dpef_pkg::DPEF_BUSY);
    assign accHold       = (accState_ff == dpef_pkg::DPEF_HOLD);
    assign readInvSet    = accActive & busDone & ~accIsWrite_ff & busEccError;
    assign illegalSet    = cmdStart & cmdIllegal;
    assign clrNoResp     = w1cHit(statusWrite, statusWrData, dpef_pkg::NO_RESP_BIT);
    assign clrReadInv    = w1cHit(statusWrite, statusWrData, dpef_pkg::READ_INV_BIT);
    assign clrIllegal    = w1cHit(statusWrite, statusWrData, dpef_pkg::ILLEGAL_BIT);
    assign fillerNoResp  = failSticky_ff | noResponseFlag;
    assign fillerIllegal = illegalAccessFlag;

    // sticky status flags
    dpef_flag u_flagOverrun
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .setPulse (overrunSet),
        .clrPulse (resyncDone),
        .flag_ff  (overrunFlag)
    );

    // no-response: many causes, host clears
    dpef_flag u_flagNoResp
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .setPulse (noRespSet),
        .clrPulse (clrNoResp),
        .flag_ff  (noResponseFlag)
    );

    // read-invalid: ECC error on a debug read
    dpef_flag u_flagReadInv
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .setPulse (readInvSet),
        .clrPulse (clrReadInv),
        .flag_ff  (readInvalidFlag)
    );

    // illegal access: refused command
    dpef_flag u_flagIllegal
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .setPulse (illegalSet),
        .clrPulse (clrIllegal),
        .flag_ff  (illegalAccessFlag)
    );

    // status byte assembly, unused bits read zero
    always_comb
    begin
        debugStatusLow = dpef_pkg::STATUS_RESET;
        debugStatusLow[dpef_pkg::OVERRUN_BIT]  = overrunFlag;
        debugStatusLow[dpef_pkg::NO_RESP_BIT]  = noResponseFlag;
        debugStatusLow[dpef_pkg::READ_INV_BIT] = readInvalidFlag;
        debugStatusLow[dpef_pkg::ILLEGAL_BIT]  = illegalAccessFlag;
    end

    // access tracker: busy searches for a free cycle, hold waits out external wait
    always_comb
    begin
        nxt_accState = accState_ff;
        nxt_stealCnt = stealCnt_ff;
        unique case (accState_ff)
            dpef_pkg::DPEF_IDLE:
            begin
                nxt_stealCnt = dpef_pkg::CYCLE_SELECT_A_CNT_ZERO;
                if (startAccess)
                    nxt_accState = dpef_pkg::DPEF_BUSY;
            end
            dpef_pkg::DPEF_BUSY:
            begin
                if (busDone)
                    nxt_accState = dpef_pkg::DPEF_IDLE;
                else if (noRespSet)
                    nxt_accState = dpef_pkg::DPEF_HOLD;
                else if (!busFreeCycle)
                    nxt_stealCnt = stealCnt_ff + 10'h001;
            end
            dpef_pkg::DPEF_HOLD:
            begin
                if (busDone || !extWaitSync)
                    nxt_accState = dpef_pkg::DPEF_IDLE;
            end
        endcase
    end

    // abort fires when the hold ends without completion
    assign busAbort   = accHold & ~extWaitSync & ~busDone;
    assign busRequest = accBusy;

    // failure of the current access selects filler data
    assign nxt_failSticky = (startAccess | (cmdStart & ~memCmd)) ? 1'b0
                          : (failSticky_ff | noRespSet);

    // enter-debug request waits for wait mode to end
    assign nxt_enterPending = (enterPending_ff | waitEnterDebug) & waitMode;
    assign enterDebugReq    = (cmdStart & cmdIsEnterDebug & ~waitMode & ~overrunFlag)
                            | (enterPending_ff & ~waitMode);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            accState_ff     <= dpef_pkg::DPEF_IDLE;
            stealCnt_ff     <= dpef_pkg::CYCLE_SELECT_A_CNT_ZERO;
            accIsWrite_ff   <= 1'b0;
            failSticky_ff   <= 1'b0;
            enterPending_ff <= 1'b0;
            wirePrev_ff     <= 1'b0; // synced pin also resets low: no false fall
        end
        else
        begin
            accState_ff     <= nxt_accState;
            stealCnt_ff     <= nxt_stealCnt;
            accIsWrite_ff   <= startAccess ? cmdIsWrite : accIsWrite_ff;
            failSticky_ff   <= nxt_failSticky;
            enterPending_ff <= nxt_enterPending;
            wirePrev_ff     <= wirePinSync;
        end
    end

    // host data: filler for failed or illegal accesses, real data otherwise
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            hostReadData_ff <= dpef_pkg::HOST_DATA_RESET;
        else if (dataByteTake)
        begin
            if (fillerNoResp)
                hostReadData_ff <= dpef_pkg::FILLER_BYTE;
            else if (fillerIllegal)
                hostReadData_ff <= dpef_pkg::FILLER_BYTE;
            else
                hostReadData_ff <= busReadData;
        end
    end
endmodule

/* File: bench/dpef_error_flags_checker.sv */
/* dpef_error_flags_checker: timing relations of the error flags.
   Bound to dpef_error_flags, sees its ports only, one clock domain. */
`timescale 1ns/1ps
module dpef_error_flags_checker
(
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // inputs watched
    input wire logic       cmdStart,
    input wire logic       cmdIllegal,
    input wire logic       cmdIsMemAccess,
    input wire logic       stopMode,
    input wire logic       clockInStopSelect,
    input wire logic       externalWaitInput,
    input wire logic       busFreeCycle,
    input wire logic       busDone,
    input wire logic       busEccError,
    input wire logic       statusWrite,
    input wire logic [7:0] statusWrData,
    input wire logic       dataByteTake,
    // outputs watched
    input wire logic       busRequest,
    input wire logic       busAbort,
    input wire logic [7:0] debugStatusLow,
    input wire logic [7:0] hostReadData_ff
);
    logic [10:0] stallCnt_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // run of stalled request cycles
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            stallCnt_ff <= 11'h000;
        else
            stallCnt_ff <= (busRequest && !busFreeCycle) ? stallCnt_ff + 11'h001 : 11'h000;

    // flag set, hold, clear and filler relations
    a_overrun_on_cmd: assert property (cmdStart && busRequest |=> debugStatusLow[4])
        else $error("no overrun on busy command");
    a_overrun_blocks: assert property (debugStatusLow[4] && !busRequest |=> !busRequest)
        else $error("access started under overrun");
    a_stall_no_response_flag: assert property (stallCnt_ff == 11'h200 |-> ##[0:2] debugStatusLow[3])
        else $error("no response flag missing");
    a_abort_waits: assert property (busAbort |-> !$past(externalWaitInput, 2))
        else $error("abort during external wait");
    a_stop_no_response_flag: assert property (cmdStart && cmdIsMemAccess && stopMode
        && !clockInStopSelect |=> debugStatusLow[3]) else $error("stop access not flagged");
    a_ecc_read_invalid_flag: assert property (busDone && busEccError && busRequest |=> debugStatusLow[2])
        else $error("read invalid not set");
    a_w1c_keep: assert property (debugStatusLow[2] && !(statusWrite && statusWrData[2])
        |=> debugStatusLow[2]) else $error("read invalid lost");
    a_w1c_clear: assert property (statusWrite && statusWrData[1]
        && !(cmdStart && cmdIllegal) |=> !debugStatusLow[1]) else $error("illegal not cleared");
    a_filler_byte: assert property (dataByteTake
        && (debugStatusLow[3] || debugStatusLow[1]) |=> hostReadData_ff == dpef_pkg::FILLER_BYTE)
        else $error("filler byte missing");
endmodule

bind dpef_error_flags dpef_error_flags_checker i_chk
(
    .clk_sys, .rst, .cmdStart, .cmdIllegal, .cmdIsMemAccess, .stopMode, .clockInStopSelect,
    .externalWaitInput, .busFreeCycle, .busDone, .busEccError, .statusWrite, .statusWrData,
    .dataByteTake, .busRequest, .busAbort, .debugStatusLow, .hostReadData_ff
);

/* File: bench/dpef_host_model.sv */
/* dpef_host_model: debug host on the single-wire pin.
   The pin has a pull-up; the host only ever pulls it low. */
`timescale 1ns/1ps
module dpef_host_model
(
    // clock and pull request
    input  wire logic clk_sys,
    input  wire logic pullLow,
    // wire level
    output logic      debugWirePin
);
    logic [2:0] lowCnt_ff = 3'h0;
    // hold the wire low a few cycles, then release to the pull-up
    always_ff @(posedge clk_sys)
        lowCnt_ff <= pullLow ? 3'h6 : ((lowCnt_ff != 3'h0) ? lowCnt_ff - 3'h1 : 3'h0);
    assign debugWirePin = (lowCnt_ff == 3'h0);
endmodule

/* File: bench/debug_port_error_flags_tb.sv */
/* debug_port_error_flags_tb: random reads and corner cases of the flags.
   Drives decoder, bus and mode inputs of dpef_error_flags directly. */
`timescale 1ns/1ps
module debug_port_error_flags_tb;
    logic       clk_sys = 1'b0, rst = 1'b1, externalWaitInput = 1'b0, ackEnable = 1'b0;
    logic       cycleSelectA = 1'b0, clockInStopSelect = 1'b0, stopMode = 1'b0;
    logic       waitMode = 1'b0, waitReturning = 1'b0, ackPending = 1'b0;
    logic       busFreeCycle = 1'b0, busEccError = 1'b0, cmdWr = 1'b0;
    logic [4:0] qual = 5'h00;
    logic [6:0] stb = 7'h00;
    logic [7:0] busReadData = 8'h00, statusWrData = 8'h00, debugStatusLow, hostReadData_ff, d;
    logic       busRequest, busAbort, enterDebugReq, debugWirePin;
    logic [31:0] seed = 32'h628F;
    int         err_count = 0;
    int         checks = 0;
    wire logic [2:0] seenOut = {enterDebugReq, busAbort, busRequest};

    always #12.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // one-cycle strobes: 0 resync 1 retrieve 2 take 3 done 4 write 5 cmd 6 pull
    task automatic pulse(input logic [6:0] m, input logic [4:0] q);
        @(posedge clk_sys);
        stb <= m;
        qual <= q;
        @(posedge clk_sys);
        stb <= 7'h00;
        #1;
    endtask
    task automatic wst(input logic [7:0] v);
        statusWrData <= v;
        pulse(7'h10, 5'h00);
    endtask
    task automatic waitfor(input int k);
        #1;
        for (int i = 0; i < 40; i++)
        begin
            if (seenOut[k] === 1'b1)
                return;
            cyc(1);
        end
        err_count++;
        end_of_test();
    endtask

    dpef_error_flags i_dut
    (
        .clk_sys, .rst, .debugWirePin, .externalWaitInput, .ackEnable, .cycleSelectA,
        .clockInStopSelect, .debugModeActive(1'b0), .stopMode, .waitMode, .waitReturning,
        .cmdStart(stb[5]), .cmdIsMemAccess(qual[4]), .cmdIsWrite(cmdWr), .cmdIsSamplePc(qual[3]),
        .cmdIsEnterDebug(qual[2]), .cmdIsCoreReg(qual[1]), .cmdIllegal(qual[0]),
        .resyncDone(stb[0]), .ackPending, .retrieveStart(stb[1]), .busFreeCycle,
        .busDone(stb[3]), .busEccError, .busReadData, .busRequest, .busAbort, .enterDebugReq,
        .statusWrite(stb[4]), .statusWrData, .debugStatusLow, .dataByteTake(stb[2]),
        .hostReadData_ff
    );
    dpef_host_model i_host (.clk_sys, .pullLow(stb[6]), .debugWirePin);

    // scenario sequence
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        busFreeCycle <= 1'b1;
        for (int n = 0; n < 6; n++)
        begin
            d = 8'(rnd());
            pulse(7'h20, 5'h10);
            waitfor(0);
            busReadData <= d;
            busEccError <= d[0];
            pulse(7'h08, 5'h00);
            pulse(7'h04, 5'h00);
            chk({debugStatusLow, hostReadData_ff}, {5'h00, d[0], 2'b00, d});
            wst(8'hFB);
            chk({8'h00, debugStatusLow}, {13'h0000, d[0], 2'b00});
            wst(8'h04);
            chk({8'h00, debugStatusLow}, 16'h0000);
        end
        busEccError <= 1'b0;
        // command while busy, refused command, resync
        pulse(7'h20, 5'h10);
        waitfor(0);
        pulse(7'h20, 5'h10);
        chk({15'h0000, debugStatusLow[4]}, 16'h0001);
        pulse(7'h08, 5'h00);
        pulse(7'h20, 5'h10);
        cyc(2);
        wst(8'h10);
        chk({busRequest, debugStatusLow[4]}, 16'h0001);
        pulse(7'h01, 5'h00);
        chk({15'h0000, debugStatusLow[4]}, 16'h0000);
        // illegal memory, register and plain illegal attempts
        for (int i = 0; i < 3; i++)
        begin
            pulse(7'h20, 5'h01 | (5'h10 >> (3 * i)));
            pulse(7'h04, 5'h00);
            chk({7'h00, debugStatusLow[1], hostReadData_ff}, 16'h01EE);
            wst(8'h02);
        end
        // no free cycle; external wait holds off the abort
        busFreeCycle <= 1'b0;
        externalWaitInput <= 1'b1;
        pulse(7'h20, 5'h10);
        cyc(dpef_pkg::CYCLE_SELECT_A_LIMIT - 3);
        chk({15'h0000, debugStatusLow[3]}, 16'h0000);
        cyc(14);
        chk({busAbort, debugStatusLow[3]}, 16'h0001);
        externalWaitInput <= 1'b0;
        waitfor(1);
        pulse(7'h04, 5'h00);
        chk({8'h00, hostReadData_ff}, 16'h00EE);
        wst(8'h08);
        // cycle stealing: retrieval before the access completes
        cycleSelectA <= 1'b1;
        pulse(7'h20, 5'h10);
        pulse(7'h02, 5'h00);
        chk({15'h0000, debugStatusLow[3]}, 16'h0001);
        waitfor(1);
        wst(8'h08);
        // unfinished write when the next command starts
        cmdWr <= 1'b1;
        pulse(7'h20, 5'h10);
        cmdWr <= 1'b0;
        pulse(7'h20, 5'h10);
        chk({14'h0000, debugStatusLow[4:3]}, 16'h0003);
        waitfor(1);
        pulse(7'h01, 5'h00);
        wst(8'h08);
        busFreeCycle <= 1'b1;
        // stop without clock (memory, pc sampling), then wait mode commands
        stopMode <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            if (i == 2)
                {stopMode, waitMode} <= 2'b01;
            pulse(7'h20, (i < 2) ? (5'h10 >> i) : ((i == 4) ? 5'h04 : 5'h02));
            chk({15'h0000, debugStatusLow[3]}, 16'h0001);
            if (i < 4)
                wst(8'h08);
        end
        {waitMode, waitReturning} <= 2'b01;
        waitfor(2);
        wst(8'h08);
        pulse(7'h20, 5'h02);
        chk({15'h0000, debugStatusLow[3]}, 16'h0001);
        waitReturning <= 1'b0;
        // host pulls the wire low while an acknowledge is pending
        {ackEnable, ackPending} <= 2'b11;
        pulse(7'h40, 5'h00);
        cyc(6);
        chk({15'h0000, debugStatusLow[4]}, 16'h0001);
        end_of_test();
    end
endmodule
